// [hdl/osrt_pkg.sv]
// Purpose: Shared constants and types of the operation status register tree.
// Assumes: One 16-bit status register per node of the tree, four nodes.
// Notes:   Masks mark the implemented bits; all others read as zero.

package osrt_pkg;

   // ****************************************************************
   // Widths and sizes.
   // ****************************************************************
   localparam int unsigned OSRT_WIDTH = 16;
   localparam int unsigned OSRT_NREGS = 4;
   localparam int unsigned OSRT_DIGITS = 5;

   // ****************************************************************
   // Register selectors and register stages.
   // ****************************************************************
   typedef enum logic [1:0]
   {
      OSRT_REG_OPER = 2'h0,
      OSRT_REG_SHUT = 2'h1,
      OSRT_REG_PROT = 2'h2,
      OSRT_REG_SHARE = 2'h3
   } osrt_reg_type;

   typedef enum logic [2:0]
   {
      OSRT_FLD_COND = 3'h0,
      OSRT_FLD_EVENT = 3'h1,
      OSRT_FLD_ENABLE = 3'h2,
      OSRT_FLD_PTR = 3'h3,
      OSRT_FLD_NTR = 3'h4
   } osrt_field_type;

   // Query sequencer states, Gray along idle to convert.
   typedef enum logic [1:0]
   {
      OSRT_ST_IDLE = 2'b00,
      OSRT_ST_CONV = 2'b01
   } osrt_state_type;

   // ****************************************************************
   // Bit positions.
   // ****************************************************************
   localparam int unsigned OSRT_OP_CALIB = 0;
   localparam int unsigned OSRT_OP_SHUT_SUM = 9;
   localparam int unsigned OSRT_OP_LOCKOUT = 10;
   localparam int unsigned OSRT_OP_SHARE_SUM = 11;
   localparam int unsigned OSRT_OP_CV = 12;
   localparam int unsigned OSRT_OP_CC = 13;
   localparam int unsigned OSRT_OP_PROGRAM = 14;
   localparam int unsigned OSRT_SH_PROT_SUM = 0;
   localparam int unsigned OSRT_SH_INPUT_A = 1;
   localparam int unsigned OSRT_SH_EXT = 3;
   localparam int unsigned OSRT_PR_OV = 0;
   localparam int unsigned OSRT_PR_UV = 1;
   localparam int unsigned OSRT_PR_OC = 2;
   localparam int unsigned OSRT_PR_AC_OFF = 4;
   localparam int unsigned OSRT_PR_OT = 5;
   localparam int unsigned OSRT_PR_FOLDBACK = 7;
   localparam int unsigned OSRT_PR_FAN = 8;
   localparam int unsigned OSRT_CS_CONTROLLER = 0;
   localparam int unsigned OSRT_CS_FOLLOWER = 1;

   // ****************************************************************
   // Implemented-bit masks and reset values.
   // ****************************************************************
   localparam logic [15:0] OSRT_MASK_OPER = 16'h7e01;
   localparam logic [15:0] OSRT_MASK_SHUT = 16'h000b;
   localparam logic [15:0] OSRT_MASK_PROT = 16'h01b7;
   localparam logic [15:0] OSRT_MASK_SHARE = 16'h0003;
   localparam logic [15:0] OSRT_RST_COND = 16'h0000;
   localparam logic [15:0] OSRT_RST_EVENT = 16'h0000;
   localparam logic [15:0] OSRT_RST_ENABLE = 16'h0000;
   localparam logic [15:0] OSRT_RST_PTR = 16'hffff;
   localparam logic [15:0] OSRT_RST_NTR = 16'h0000;

endpackage : osrt_pkg

// [hdl/osrt_bin2dec.sv]
// Purpose: Serial binary to packed-BCD converter for query answers.
// Assumes: A start is only given while the converter is idle.
// Notes:   Takes WIDTH cycles; the digits come from a register.

`timescale 1ns/1ns

module osrt_bin2dec
   import osrt_pkg::*;
#(
   parameter int unsigned WIDTH = OSRT_WIDTH,
   parameter int unsigned DIGITS = OSRT_DIGITS
)
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Request.
   input wire logic i_start,
   input wire logic [WIDTH-1:0] i_value,
   // Answer.
   output logic o_done,
   output logic [4*DIGITS-1:0] o_digits
);

   localparam int unsigned CW = $clog2(WIDTH + 1);

   typedef struct packed
   {
      logic busy;
      logic done;
      logic [CW-1:0] cnt;
      logic [WIDTH-1:0] shift;
      logic [4*DIGITS-1:0] bcd;
   } osrt_b2d_type;

   osrt_b2d_type s_q;
   osrt_b2d_type s_d;

   // ****************************************************************
   // Double dabble, one input bit per cycle.
   // ****************************************************************
   always_comb
   begin
      logic [4*DIGITS-1:0] adj;
      adj = s_q.bcd;
      s_d = s_q;
      s_d.done = 1'b0;
      if (s_q.busy)
      begin
         // Digits of five or more get three added before the shift.
         for (int k = 0; k < DIGITS; k++)
         begin
            if (adj[4*k +: 4] >= 4'h5)
            begin
               adj[4*k +: 4] = adj[4*k +: 4] + 4'h3;
            end
         end
         {s_d.bcd, s_d.shift} = {adj[4*DIGITS-2:0], s_q.shift, 1'b0};
         s_d.cnt = s_q.cnt - CW'(1);
         if (s_q.cnt == CW'(1))
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
      else if (i_start)
      begin
         s_d.busy = 1'b1;
         s_d.cnt = CW'(WIDTH);
         s_d.shift = i_value;
         s_d.bcd = '0;
      end
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_done = s_q.done;
   assign o_digits = s_q.bcd;

endmodule : osrt_bin2dec

// [hdl/osrt_status_tree.sv]
// Purpose: Operation status register tree with three sub-registers.
// Assumes: Condition sources are synchronous levels from the core.
// Notes:   Queries are answered as packed decimal digits.
//
// Behaviour
// - Each register 16 bits, full stages, one summary.
// - Summary is OR of enabled event bits.
// - Operation bit 0 shows calibration mode.
// - Operation bit 9 carries shutdown summary.
// - Operation bit 11 carries share-role summary.
// - Bits 12, 13 show constant voltage, current.
// - Operation bit 14 shows sequence program running.
// - Shutdown causes reported independently and simultaneously.
// - Shutdown bit 0 carries protection summary.
// - Shutdown bit 1 shows input_a shutdown.
// - Shutdown bit 3 shows external shutdown.
// - Protection bits 0-2: overvoltage, undervoltage, overcurrent.
// - Protection bit 4 shows mains loss trip.
// - Protection bit 5 shows overtemperature trip.
// - Protection bit 7 foldback, bit 8 fan.
// - Share bit 0 controller, bit 1 follower.
// - Every query answer is returned in decimal.

`timescale 1ns/1ns

module osrt_status_tree
   import osrt_pkg::*;
#(
   parameter int unsigned WIDTH = OSRT_WIDTH
)
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Operation condition sources.
   input wire logic i_calibrating,
   input wire logic i_local_lockout,
   input wire logic i_const_voltage,
   input wire logic i_const_current,
   input wire logic i_program_running,
   // Shutdown condition sources.
   input wire logic i_input_a_shutdown,
   input wire logic i_ext_shutdown,
   // Protection condition sources.
   input wire logic i_overvoltage_trip,
   input wire logic i_undervoltage_trip,
   input wire logic i_overcurrent_trip,
   input wire logic i_ac_off_trip,
   input wire logic i_overtemp_trip,
   input wire logic i_foldback_trip,
   input wire logic i_fan_fail_trip,
   // Share role sources.
   input wire logic i_share_controller,
   input wire logic i_share_follower,
   // Query and configuration port.
   input wire logic i_cmd_valid,
   input wire logic i_cmd_write,
   input wire logic [1:0] i_cmd_reg,
   input wire logic [2:0] i_cmd_field,
   input wire logic [WIDTH-1:0] i_cmd_wdata,
   output logic o_cmd_ready,
   // Query answer.
   output logic o_rsp_valid,
   output logic [4*OSRT_DIGITS-1:0] o_rsp_digits,
   // Summary towards the status byte.
   output logic o_status_byte_bit7
);

   typedef logic [OSRT_NREGS-1:0][WIDTH-1:0] osrt_bank_type;

   // Filter reset values as constants, so the reset branch stays static.
   localparam osrt_bank_type PTR_RESET =
   {
      WIDTH'(OSRT_RST_PTR & OSRT_MASK_SHARE),
      WIDTH'(OSRT_RST_PTR & OSRT_MASK_PROT),
      WIDTH'(OSRT_RST_PTR & OSRT_MASK_SHUT),
      WIDTH'(OSRT_RST_PTR & OSRT_MASK_OPER)
   };

   typedef struct packed
   {
      osrt_state_type state;
      osrt_bank_type cond;
      osrt_bank_type evt;
      osrt_bank_type en;
      osrt_bank_type ptr;
      osrt_bank_type ntr;
   } osrt_tree_type;

   osrt_tree_type s_q;
   osrt_tree_type s_d;
   logic [WIDTH-1:0] cond_now [OSRT_NREGS];
   logic [WIDTH-1:0] rd_value;
   logic take;
   logic conv_start;
   logic conv_done;

   // ****************************************************************
   // Helper functions.
   // ****************************************************************

   // Implemented bits of each register; the rest always read zero.
   function automatic logic [WIDTH-1:0] osrt_mask(input int unsigned r);
      logic [WIDTH-1:0] m;
      m = WIDTH'(OSRT_MASK_OPER);
      case (r)
         OSRT_REG_SHUT: m = WIDTH'(OSRT_MASK_SHUT);
         OSRT_REG_PROT: m = WIDTH'(OSRT_MASK_PROT);
         OSRT_REG_SHARE: m = WIDTH'(OSRT_MASK_SHARE);
         default: m = WIDTH'(OSRT_MASK_OPER);
      endcase
      return m;
   endfunction : osrt_mask

   // A register summary looks at latched events, not raw conditions.
   function automatic logic osrt_summary(input logic [WIDTH-1:0] evt,
                                         input logic [WIDTH-1:0] en);
      return |(evt & en);
   endfunction : osrt_summary

   // ****************************************************************
   // Condition assembly and summary fan-in.
   // ****************************************************************

   // Summaries come from registered events, so the tree has no loop.
   always_comb
   begin
      for (int r = 0; r < OSRT_NREGS; r++)
      begin
         cond_now[r] = '0;
      end
      cond_now[OSRT_REG_OPER][OSRT_OP_CALIB] = i_calibrating;
      cond_now[OSRT_REG_OPER][OSRT_OP_SHUT_SUM] =
         osrt_summary(s_q.evt[OSRT_REG_SHUT], s_q.en[OSRT_REG_SHUT]);
      // Local lockout is a plain condition with no node of its own.
      // It still passes through the filters like every other bit.
      cond_now[OSRT_REG_OPER][OSRT_OP_LOCKOUT] = i_local_lockout;
      cond_now[OSRT_REG_OPER][OSRT_OP_SHARE_SUM] =
         osrt_summary(s_q.evt[OSRT_REG_SHARE],
                      s_q.en[OSRT_REG_SHARE]);
      cond_now[OSRT_REG_OPER][OSRT_OP_CV] = i_const_voltage;
      cond_now[OSRT_REG_OPER][OSRT_OP_CC] = i_const_current;
      cond_now[OSRT_REG_OPER][OSRT_OP_PROGRAM] = i_program_running;
      // Each cause has its own bit, so several may stand at once.
      cond_now[OSRT_REG_SHUT][OSRT_SH_PROT_SUM] =
         osrt_summary(s_q.evt[OSRT_REG_PROT], s_q.en[OSRT_REG_PROT]);
      cond_now[OSRT_REG_SHUT][OSRT_SH_INPUT_A] = i_input_a_shutdown;
      cond_now[OSRT_REG_SHUT][OSRT_SH_EXT] = i_ext_shutdown;
      cond_now[OSRT_REG_PROT][OSRT_PR_OV] = i_overvoltage_trip;
      cond_now[OSRT_REG_PROT][OSRT_PR_UV] = i_undervoltage_trip;
      cond_now[OSRT_REG_PROT][OSRT_PR_OC] = i_overcurrent_trip;
      cond_now[OSRT_REG_PROT][OSRT_PR_AC_OFF] = i_ac_off_trip;
      cond_now[OSRT_REG_PROT][OSRT_PR_OT] = i_overtemp_trip;
      cond_now[OSRT_REG_PROT][OSRT_PR_FOLDBACK] = i_foldback_trip;
      cond_now[OSRT_REG_PROT][OSRT_PR_FAN] = i_fan_fail_trip;
      // Both roles are shown as given; picking one is the host's duty.
      cond_now[OSRT_REG_SHARE][OSRT_CS_CONTROLLER] =
         i_share_controller;
      cond_now[OSRT_REG_SHARE][OSRT_CS_FOLLOWER] = i_share_follower;
   end

   // ****************************************************************
   // Query port decode.
   // ****************************************************************

   // Commands are taken only while no answer is being converted.
   // Writes never leave the idle state, so settings may follow each
   // other on every cycle; only a read holds the port.
   assign o_cmd_ready = (s_q.state == OSRT_ST_IDLE);
   assign take = i_cmd_valid && o_cmd_ready;
   assign conv_start = take && !i_cmd_write;

   // Read value is picked before the event clear takes effect.
   // Field codes five to seven are spare: they answer zero and ignore
   // writes, which keeps a stray request from touching the tree.
   always_comb
   begin
      rd_value = '0;
      unique case (osrt_field_type'(i_cmd_field))
         OSRT_FLD_COND: rd_value = s_q.cond[i_cmd_reg];
         OSRT_FLD_EVENT: rd_value = s_q.evt[i_cmd_reg];
         OSRT_FLD_ENABLE: rd_value = s_q.en[i_cmd_reg];
         OSRT_FLD_PTR: rd_value = s_q.ptr[i_cmd_reg];
         OSRT_FLD_NTR: rd_value = s_q.ntr[i_cmd_reg];
         default: rd_value = '0;
      endcase
   end

   // ****************************************************************
   // Next state of the whole tree.
   // ****************************************************************

   // Host writes are masked to the implemented bits, so spare bits of
   // the filters and enables can never reach a summary.
   always_comb
   begin
      logic [WIDTH-1:0] m;
      logic [WIDTH-1:0] rise;
      logic [WIDTH-1:0] fall;
      logic hit;
      m = '0;
      rise = '0;
      fall = '0;
      hit = 1'b0;
      s_d = s_q;
      for (int r = 0; r < OSRT_NREGS; r++)
      begin
         m = osrt_mask(r);
         hit = take && (int'(i_cmd_reg) == r);
         s_d.cond[r] = cond_now[r] & m;
         rise = cond_now[r] & ~s_q.cond[r] & m;
         fall = ~cond_now[r] & s_q.cond[r] & m;
         // Clear first, then set, so a same-cycle edge is never lost.
         if (hit && !i_cmd_write && i_cmd_field == OSRT_FLD_EVENT)
         begin
            s_d.evt[r] = '0;
         end
         s_d.evt[r] = s_d.evt[r] | (rise & s_q.ptr[r])
                                 | (fall & s_q.ntr[r]);
         // Only the filter and enable stages take host writes.
         if (hit && i_cmd_write)
         begin
            if (i_cmd_field == OSRT_FLD_ENABLE)
            begin
               s_d.en[r] = i_cmd_wdata & m;
            end
            if (i_cmd_field == OSRT_FLD_PTR)
            begin
               s_d.ptr[r] = i_cmd_wdata & m;
            end
            if (i_cmd_field == OSRT_FLD_NTR)
            begin
               s_d.ntr[r] = i_cmd_wdata & m;
            end
         end
      end
      unique case (s_q.state)
         OSRT_ST_IDLE:
         begin
            if (conv_start)
            begin
               s_d.state = OSRT_ST_CONV;
            end
         end
         OSRT_ST_CONV:
         begin
            if (conv_done)
            begin
               s_d.state = OSRT_ST_IDLE;
            end
         end
         default: s_d.state = OSRT_ST_IDLE;
      endcase
   end

   // State register with documented reset values.
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s_q.state <= OSRT_ST_IDLE;
         s_q.ptr <= PTR_RESET;
         for (int r = 0; r < OSRT_NREGS; r++)
         begin
            s_q.cond[r] <= WIDTH'(OSRT_RST_COND);
            s_q.evt[r] <= WIDTH'(OSRT_RST_EVENT);
            s_q.en[r] <= WIDTH'(OSRT_RST_ENABLE);
            s_q.ntr[r] <= WIDTH'(OSRT_RST_NTR);
         end
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Decimal answer path.
   // ****************************************************************

   // Serial conversion trades sixteen cycles of latency for area.
   // The value is captured at the taking edge, so a condition that
   // moves during the conversion shows up only in the next answer.
   osrt_bin2dec #(
      .WIDTH(WIDTH),
      .DIGITS(OSRT_DIGITS)
   ) u_bin2dec (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_start(conv_start),
      .i_value(rd_value),
      .o_done(conv_done),
      .o_digits(o_rsp_digits)
   );

   assign o_rsp_valid = conv_done;

   // Operation summary feeds the status byte.
   // It is combinational, so the status byte moves in the same cycle as
   // the event or enable register of the operation node.
   assign o_status_byte_bit7 =
      osrt_summary(s_q.evt[OSRT_REG_OPER], s_q.en[OSRT_REG_OPER]);

endmodule : osrt_status_tree

// [sim/osrt_host.sv]
// Purpose: Remote host model that issues queries and settings.
// Assumes: One request at a time, held until the tree takes it.
// Notes:   Released write data is inverted so stale values never match.

`timescale 1ns/1ns

module osrt_host
   import osrt_pkg::*;
(
   // Clock and handshake.
   input wire logic i_core_clk,
   input wire logic i_cmd_ready,
   // Request towards the tree.
   output logic o_valid,
   output logic o_write,
   output logic [1:0] o_reg,
   output logic [2:0] o_field,
   output logic [OSRT_WIDTH-1:0] o_wdata,
   // Share role chosen by the host.
   output logic o_ctrl_role
);
   logic hold_role;

   // Nothing is shared here, so the host holds no controller role until hold_role is set.
   assign o_ctrl_role = hold_role;

   initial
   begin
      o_valid = 1'b0;
      o_write = 1'b0;
      o_reg = 2'h0;
      o_field = 3'h0;
      o_wdata = 16'h0000;
      hold_role = 1'b0;
   end

   // One request, held until the edge that samples ready high.
   task automatic issue(input logic w, input logic [1:0] r,
                        input logic [2:0] f, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      o_valid <= 1'b1;
      o_write <= w;
      o_reg <= r;
      o_field <= f;
      o_wdata <= d;
      do
      begin
         @(posedge i_core_clk);
         n++;
      end
      while (i_cmd_ready !== 1'b1 && n < 100);
      o_valid <= 1'b0;
      o_wdata <= ~d;
   endtask : issue
endmodule : osrt_host

// [sim/osrt_chk_properties.sv]
// Purpose: Timing checks on the query port of the status tree.
// Assumes: Sees the top module's ports only.
// Notes:   Bound to the tree at the foot of this file.

`timescale 1ns/1ns

module osrt_chk
   import osrt_pkg::*;
(
   // Watched ports.
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_cmd_valid,
   input wire logic i_cmd_write,
   input wire logic o_cmd_ready,
   input wire logic o_rsp_valid,
   input wire logic [4*OSRT_DIGITS-1:0] o_rsp_digits
);
   logic rd_take;

   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);

   // A read is taken when a request meets ready.
   assign rd_take = i_cmd_valid && o_cmd_ready && !i_cmd_write;

   // ****************************************************************
   // Answer timing and answer format.
   // ****************************************************************
   property p_rsp_lat;
      rd_take |=> ##16 o_rsp_valid;
   endproperty
   a_rsp_lat: assert property (p_rsp_lat)
      else $error("answer not on the seventeenth cycle");
   property p_busy;
      rd_take |=> (!o_cmd_ready && !o_rsp_valid) [*8];
   endproperty
   a_busy: assert property (p_busy)
      else $error("port not busy during conversion");
   property p_pulse;
      o_rsp_valid |=> !o_rsp_valid && o_cmd_ready;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("answer pulse or ready return wrong");
   property p_hold;
      o_cmd_ready && !rd_take |=> $stable(o_rsp_digits);
   endproperty
   a_hold: assert property (p_hold)
      else $error("answer digits moved while idle");
   property p_bcd;
      o_rsp_valid |-> o_rsp_digits[3:0] <= 4'h9 && o_rsp_digits[7:4] <= 4'h9
         && o_rsp_digits[11:8] <= 4'h9 && o_rsp_digits[15:12] <= 4'h9
         && o_rsp_digits[19:16] <= 4'h6;
   endproperty
   a_bcd: assert property (p_bcd)
      else $error("answer is not decimal");
   property p_only_busy;
      o_rsp_valid |-> !$past(o_cmd_ready);
   endproperty
   a_only_busy: assert property (p_only_busy)
      else $error("answer without a read in progress");
   property p_ready_ret;
      $rose(o_cmd_ready) |-> $past(o_rsp_valid);
   endproperty
   a_ready_ret: assert property (p_ready_ret)
      else $error("ready returned before the answer");
   property p_wr_fast;
      i_cmd_valid && o_cmd_ready && i_cmd_write |=> o_cmd_ready;
   endproperty
   a_wr_fast: assert property (p_wr_fast)
      else $error("write made the port busy");
endmodule : osrt_chk

bind osrt_status_tree osrt_chk u_chk (.i_core_clk, .i_arst_n,
   .i_cmd_valid, .i_cmd_write, .o_cmd_ready, .o_rsp_valid, .o_rsp_digits);

// [sim/tb_top.sv]
// Purpose: Self-checking bench of the operation status register tree.
// Assumes: Answers come back in the order of the reads.
// Notes:   Expected answers wait in a queue until the answer pulse.

`timescale 1ns/1ns

module tb_top
   import osrt_pkg::*;
;
   localparam int RG[16] = '{0,0,0,0,0,1,1,2,2,2,2,2,2,2,3,3};
   localparam int BT[16] = '{0,10,12,13,14,1,3,0,1,2,4,5,7,8,0,1};
   localparam logic [15:0] MK[4] = '{OSRT_MASK_OPER, OSRT_MASK_SHUT,
      OSRT_MASK_PROT, OSRT_MASK_SHARE};
   logic clk, arst_n, valid, write, ready, rsp_valid, bit7, role;
   logic [1:0] rsel;
   logic [2:0] fsel;
   logic [15:0] wdata, src;
   logic [19:0] digits;
   logic [19:0] expq[$];
   logic [31:0] rnd;
   int num_errors = 0;
   int n_compared = 0;

   osrt_host u_host (.i_core_clk(clk), .i_cmd_ready(ready), .o_valid(valid),
      .o_write(write), .o_reg(rsel), .o_field(fsel), .o_wdata(wdata),
      .o_ctrl_role(role));

   osrt_status_tree uut (.i_core_clk(clk), .i_arst_n(arst_n),
      .i_calibrating(src[0]), .i_local_lockout(src[1]),
      .i_const_voltage(src[2]), .i_const_current(src[3]),
      .i_program_running(src[4]), .i_input_a_shutdown(src[5]),
      .i_ext_shutdown(src[6]), .i_overvoltage_trip(src[7]),
      .i_undervoltage_trip(src[8]), .i_overcurrent_trip(src[9]),
      .i_ac_off_trip(src[10]), .i_overtemp_trip(src[11]),
      .i_foldback_trip(src[12]), .i_fan_fail_trip(src[13]),
      .i_share_controller(src[14] | role), .i_share_follower(src[15]),
      .i_cmd_valid(valid), .i_cmd_write(write), .i_cmd_reg(rsel),
      .i_cmd_field(fsel), .i_cmd_wdata(wdata), .o_cmd_ready(ready),
      .o_rsp_valid(rsp_valid), .o_rsp_digits(digits),
      .o_status_byte_bit7(bit7));

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction : xs

   // Own decimal packing, digit 0 lowest.
   function automatic logic [19:0] dec(input logic [15:0] v);
      int x;
      x = v;
      dec = 20'h00000;
      for (int i = 0; i < 5; i++)
      begin
         dec[4*i +: 4] = 4'(x % 10);
         x = x / 10;
      end
   endfunction : dec

   task automatic check(input string nm, input logic [19:0] seen,
                        input logic [19:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic rd(input int r, input int f, input logic [15:0] e);
      expq.push_back(dec(e));
      u_host.issue(1'b0, 2'(r), 3'(f), 16'h0000);
   endtask : rd

   task automatic wr(input int r, input int f, input logic [15:0] d);
      u_host.issue(1'b1, 2'(r), 3'(f), d);
   endtask : wr

   // Sources move just after an edge, then settle through the tree.
   task automatic drive(input logic [15:0] v);
      @(posedge clk);
      src <= v;
      repeat (6) @(posedge clk);
   endtask : drive

   task automatic report_and_stop;
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // ****************************************************************
   // Clock, answer monitor and watchdog.
   // ****************************************************************
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // An answer with no note pending compares against unknown and fails.
   always @(posedge clk)
      if (rsp_valid === 1'b1)
         check("answer", digits, expq.size() ? expq.pop_front() : 'x);

   // Some hundred and ten transfers fit well inside this span.
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   initial
   begin
      src = 16'h0000;
      arst_n = 1'b0;
      rnd = 32'h00000009;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      // Reset contents of every stage and of an unused field code.
      for (int r = 0; r < 4; r++)
         for (int f = 0; f < 6; f++)
            rd(r, f, (f == 3) ? MK[r] : 16'h0000);
      // Random enables read back masked; condition writes are dropped.
      for (int r = 0; r < 4; r++)
      begin
         rnd = xs(rnd);
         wr(r, 2, rnd[15:0]);
         wr(r, 0, rnd[31:16]);
         rd(r, 2, rnd[15:0] & MK[r]);
         rd(r, 0, 16'h0000);
         wr(r, 2, 16'h0000);
      end
      // Each source alone: its bit, a latched event, then a clear.
      for (int k = 0; k < 16; k++)
      begin
         drive(16'h0001 << k);
         rd(RG[k], 0, 16'h0001 << BT[k]);
         rd(RG[k], 1, 16'h0001 << BT[k]);
         rd(RG[k], 1, 16'h0000);
         drive(16'h0000);
      end
      // Two shutdown causes at once, then falling edges only.
      drive(16'h0060);
      rd(1, 0, 16'h000a);
      rd(1, 1, 16'h000a);
      wr(1, 4, 16'hffff);
      wr(1, 3, 16'h0000);
      drive(16'h0000);
      rd(1, 1, 16'h000a);
      drive(16'h0060);
      rd(1, 1, 16'h0000);
      drive(16'h0000);
      rd(1, 1, 16'h000a);
      wr(1, 3, 16'hffff);
      wr(1, 4, 16'h0000);
      // Overvoltage climbs the tree to the status byte.
      wr(2, 2, 16'h0001);
      wr(1, 2, 16'h0001);
      wr(0, 2, 16'h0200);
      drive(16'h0080);
      check("byte bit", {19'h00000, bit7}, 20'h00001);
      rd(1, 0, 16'h0001);
      rd(0, 0, 16'h0200);
      rd(0, 1, 16'h0200);
      rd(0, 2, 16'h0200);
      repeat (2) @(posedge clk);
      check("byte bit", {19'h00000, bit7}, 20'h00000);
      // Controller role held by the host feeds the share summary.
      wr(3, 2, 16'h0001);
      @(posedge clk);
      u_host.hold_role <= 1'b1;
      repeat (6) @(posedge clk);
      rd(0, 0, 16'h0a00);
      drive(16'h0000);
      repeat (40) @(posedge clk);
      check("pending", 20'(expq.size()), 20'h00000);
      report_and_stop();
   end
endmodule : tb_top
